/* File: design/nprd_pkg.sv */
// Package of offsets, field positions and reset values for the paged register decoder.
package nprd_pkg;
  // ==========================================================================
  // Offsets within a page and in the upper range
  // ==========================================================================
  localparam logic [3:0] OFS_COMMAND = 4'h0;
  localparam logic [3:0] OFS_01 = 4'h1;
  localparam logic [3:0] OFS_02 = 4'h2;
  localparam logic [3:0] OFS_03 = 4'h3;
  localparam logic [3:0] OFS_04 = 4'h4;
  localparam logic [3:0] OFS_05 = 4'h5;
  localparam logic [3:0] OFS_06 = 4'h6;
  localparam logic [3:0] OFS_07 = 4'h7;
  localparam logic [3:0] OFS_08 = 4'h8;
  localparam logic [3:0] OFS_09 = 4'h9;
  localparam logic [3:0] OFS_0A = 4'hA;
  localparam logic [3:0] OFS_0B = 4'hB;
  localparam logic [3:0] OFS_0C = 4'hC;
  localparam logic [3:0] OFS_0D = 4'hD;
  localparam logic [3:0] OFS_0E = 4'hE;
  localparam logic [3:0] OFS_0F = 4'hF;
  // Bits 4:3 of the register offset pick paged space, data port or reset port.
  localparam logic [1:0] RANGE_PAGED_LO = 2'h0;
  localparam logic [1:0] RANGE_PAGED_HI = 2'h1;
  localparam logic [1:0] RANGE_DATA = 2'h2;
  localparam logic [1:0] RANGE_RESET = 2'h3;
  localparam logic [1:0] PAGE_0 = 2'h0;
  localparam logic [1:0] PAGE_1 = 2'h1;
  localparam logic [1:0] PAGE_2 = 2'h2;
  localparam logic [1:0] PAGE_3 = 2'h3;
  // ==========================================================================
  // Field positions and masks
  // ==========================================================================
  localparam int CMD_PAGE_HI = 7;
  localparam int CMD_PAGE_LO = 6;
  localparam int CMD_TRIGGER = 2;
  localparam int CMD_GO = 1;
  localparam int CMD_HALT = 0;
  localparam int IRQ_RESET_STATE = 7;
  localparam logic [7:0] TX_STATUS_MASK = 8'hDD;
  localparam logic [7:0] RETRY_MASK = 8'h0F;
  localparam logic [7:0] RX_STATUS_MASK = 8'hF7;
  localparam logic [7:0] RX_CONFIG_MASK = 8'h3F;
  localparam logic [7:0] TX_CONFIG_MASK = 8'h1F;
  localparam logic [7:0] DATA_CONFIG_MASK = 8'h7F;
  localparam logic [7:0] IRQ_MASK_MASK = 8'h7F;
  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] COMMAND_RESET = 8'h21;
  localparam logic [7:0] IRQ_STATUS_RESET = 8'h80;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : nprd_pkg

/* File: design/nprd_top.sv */
// Paged register bank and decoder of an Ethernet controller on classic Wishbone.
`timescale 1ns/1ps

// Functional notes
// - Four pages of sixteen registers, chosen by command bits.
// - Page select zero decodes page 0.
// - Values 01, 10, 11 select pages 1, 2, 3.
// - Command register at 00 on every page.
// - Offsets 10-17 reach the remote data port.
// - Ring boundary at 03 is read/write.
// - 05 reads retry tally, writes length low.
// - 06 reads prefetch byte, writes length high.
// - Interrupt status at 07 read/write.
// - 0A/0B read fixed identity, write remote count.
// - 0C reads receive status.
// - 0D-0F read three tally counters.
// - 0D write sets transmit configuration.
// - 0E write sets data configuration.
// - 0F write sets interrupt mask, bit 7 reserved.
// - Page 2 reads back page-0 ring start/stop, transmit start and config registers.
module nprd_top #(
  parameter logic [7:0] IDENT_0 = 8'hA5, // Value is arbitrary.
  parameter logic [7:0] IDENT_1 = 8'h5A  // Value is arbitrary.
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [6:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [15:0] LOCAL_DMA_ADDR,
  input wire logic [15:0] REMOTE_CUR_ADDR,
  input wire logic [7:0] TX_STATUS,
  input wire logic [3:0] RETRY_TALLY,
  input wire logic [7:0] PREFETCH_BYTE,
  input wire logic [7:0] RX_STATUS,
  input wire logic [7:0] TALLY_0,
  input wire logic [7:0] TALLY_1,
  input wire logic [7:0] TALLY_2,
  input wire logic [6:0] IRQ_EVENTS,
  input wire logic [7:0] DATA_PORT_RDATA,
  output logic DATA_PORT_RD,
  output logic DATA_PORT_WR,
  output logic [7:0] DATA_PORT_WDATA,
  output logic SOFT_RESET_PULSE,
  output logic TRANSMIT_TRIGGER,
  output logic GO_COMMAND,
  output logic HALT_COMMAND,
  output logic [2:0] REMOTE_DMA_COMMAND,
  output logic [7:0] RING_START_PAGE,
  output logic [7:0] RING_STOP_PAGE,
  output logic [7:0] RING_BOUNDARY_PAGE,
  output logic [7:0] TRANSMIT_START_PAGE,
  output logic [15:0] TRANSMIT_LENGTH,
  output logic [15:0] REMOTE_START_ADDR,
  output logic [15:0] REMOTE_COUNT,
  output logic [7:0] RECEIVE_CONFIG,
  output logic [7:0] TRANSMIT_CONFIG,
  output logic [7:0] DATA_CONFIG,
  output logic [7:0] INTERRUPT_MASK,
  output logic [47:0] STATION_ADDR,
  output logic [7:0] RING_WRITE_PAGE,
  output logic [63:0] HASH_FILTER
);
  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // Each byte register takes one aligned word; only lane 0 carries data.
  logic req;
  logic wr_en;
  logic rd_en;
  logic ack_r;
  logic [4:0] ofs;
  logic [1:0] page;
  logic [3:0] sub;
  logic [7:0] wbyte;
  logic paged;
  logic [7:0] command_r;
  logic [7:0] irq_status_r;
  logic [7:0] station_r [0:5];
  logic [7:0] hash_r [0:7];
  logic [7:0] rdata_nxt;

  // Gating with ack keeps a held request from being taken twice, at the cost of
  // one wait state per access.
  assign req = WB_CYC_I & WB_STB_I & ~ack_r;
  assign ofs = WB_ADR_I[6:2];
  assign sub = ofs[3:0];
  assign wbyte = WB_DAT_I[7:0];
  assign wr_en = req & WB_WE_I & WB_SEL_I[0];
  assign rd_en = req & ~WB_WE_I;
  // Bits 4:3 of the offset pick the paged space, the data port or the reset port.
  function automatic logic in_range(input logic [4:0] o, input logic [1:0] r);
    in_range = (o[4:3] == r);
  endfunction : in_range

  // A match on one offset, qualified by the caller's page or enable term.
  function automatic logic hit(input logic pg_ok, input logic [3:0] s, input logic [3:0] o);
    hit = pg_ok & (s == o);
  endfunction : hit

  logic p0w;
  logic p1w;
  logic cmd_wr;
  logic data_sel;
  logic reset_sel;

  // The page comes straight from the command register, so the access right after a
  // page change already decodes against the new page.
  assign page = command_r[nprd_pkg::CMD_PAGE_HI:nprd_pkg::CMD_PAGE_LO];
  assign paged = in_range(ofs, nprd_pkg::RANGE_PAGED_LO)
    | in_range(ofs, nprd_pkg::RANGE_PAGED_HI);
  assign data_sel = in_range(ofs, nprd_pkg::RANGE_DATA);
  assign reset_sel = in_range(ofs, nprd_pkg::RANGE_RESET);
  // The command register answers on every page, so its decode ignores the page.
  assign cmd_wr = wr_en & hit(paged, sub, nprd_pkg::OFS_COMMAND);
  assign p0w = wr_en & paged & (page == nprd_pkg::PAGE_0);
  assign p1w = wr_en & paged & (page == nprd_pkg::PAGE_1);

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  // Ack stands for one cycle; the master has released the request by the next edge.
  assign WB_ACK_O = ack_r;

  // ==========================================================================
  // Command register and its command strobes
  // ==========================================================================
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      // Reset leaves the device halted on page 0 with remote transfers aborted.
      command_r <= nprd_pkg::COMMAND_RESET;
    else if (cmd_wr)
      command_r <= wbyte;
  end

  // The go, halt and trigger bits are also issued as one-cycle strobes.
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TRANSMIT_TRIGGER <= 1'b0;
      GO_COMMAND <= 1'b0;
      HALT_COMMAND <= 1'b0;
    end
    else
    begin
      TRANSMIT_TRIGGER <= cmd_wr & wbyte[nprd_pkg::CMD_TRIGGER];
      GO_COMMAND <= cmd_wr & wbyte[nprd_pkg::CMD_GO];
      HALT_COMMAND <= cmd_wr & wbyte[nprd_pkg::CMD_HALT];
    end
  end

  assign REMOTE_DMA_COMMAND = command_r[5:3];

  // ==========================================================================
  // Page-0 write registers
  // ==========================================================================
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      RING_START_PAGE <= nprd_pkg::ZERO_BYTE;
      RING_STOP_PAGE <= nprd_pkg::ZERO_BYTE;
      RING_BOUNDARY_PAGE <= nprd_pkg::ZERO_BYTE;
      TRANSMIT_START_PAGE <= nprd_pkg::ZERO_BYTE;
      TRANSMIT_LENGTH <= {nprd_pkg::ZERO_BYTE, nprd_pkg::ZERO_BYTE};
      REMOTE_START_ADDR <= {nprd_pkg::ZERO_BYTE, nprd_pkg::ZERO_BYTE};
      REMOTE_COUNT <= {nprd_pkg::ZERO_BYTE, nprd_pkg::ZERO_BYTE};
      RECEIVE_CONFIG <= nprd_pkg::ZERO_BYTE;
      TRANSMIT_CONFIG <= nprd_pkg::ZERO_BYTE;
      DATA_CONFIG <= nprd_pkg::ZERO_BYTE;
      INTERRUPT_MASK <= nprd_pkg::ZERO_BYTE;
    end
    else if (p0w)
    begin
      // Except at 03, each offset's read side is another register; only the write set lives here.
      case (sub)
        nprd_pkg::OFS_01: RING_START_PAGE <= wbyte;
        nprd_pkg::OFS_02: RING_STOP_PAGE <= wbyte;
        nprd_pkg::OFS_03: RING_BOUNDARY_PAGE <= wbyte;
        nprd_pkg::OFS_04: TRANSMIT_START_PAGE <= wbyte;
        nprd_pkg::OFS_05: TRANSMIT_LENGTH[7:0] <= wbyte;
        nprd_pkg::OFS_06: TRANSMIT_LENGTH[15:8] <= wbyte;
        nprd_pkg::OFS_08: REMOTE_START_ADDR[7:0] <= wbyte;
        nprd_pkg::OFS_09: REMOTE_START_ADDR[15:8] <= wbyte;
        nprd_pkg::OFS_0A: REMOTE_COUNT[7:0] <= wbyte;
        nprd_pkg::OFS_0B: REMOTE_COUNT[15:8] <= wbyte;
        // Reserved bits are dropped on the way in, so read-back shows them as zero.
        nprd_pkg::OFS_0C: RECEIVE_CONFIG <= wbyte & nprd_pkg::RX_CONFIG_MASK;
        nprd_pkg::OFS_0D: TRANSMIT_CONFIG <= wbyte & nprd_pkg::TX_CONFIG_MASK;
        nprd_pkg::OFS_0E: DATA_CONFIG <= wbyte & nprd_pkg::DATA_CONFIG_MASK;
        nprd_pkg::OFS_0F: INTERRUPT_MASK <= wbyte & nprd_pkg::IRQ_MASK_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Interrupt status flags
  // ==========================================================================
  // Writing a one clears a flag; a new event in the same cycle wins.
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      irq_status_r <= nprd_pkg::IRQ_STATUS_RESET;
    else
    begin
      if (hit(p0w, sub, nprd_pkg::OFS_07))
        irq_status_r <= (irq_status_r & ~wbyte) | {1'b0, IRQ_EVENTS};
      else
        irq_status_r <= irq_status_r | {1'b0, IRQ_EVENTS};
      // Halt wins when both strobes fire in the same cycle, so a command with both bits set leaves the flag showing halted.
      if (HALT_COMMAND)
        irq_status_r[nprd_pkg::IRQ_RESET_STATE] <= 1'b1;
      else if (GO_COMMAND)
        irq_status_r[nprd_pkg::IRQ_RESET_STATE] <= 1'b0;
    end
  end

  // ==========================================================================
  // Page-1 station address, write page and hash filter
  // ==========================================================================
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < 6; i++)
        station_r[i] <= nprd_pkg::ZERO_BYTE;
      for (int j = 0; j < 8; j++)
        hash_r[j] <= nprd_pkg::ZERO_BYTE;
      RING_WRITE_PAGE <= nprd_pkg::ZERO_BYTE;
    end
    else if (p1w)
    begin
      // Page 1 is a plain read/write bank; offset 7 holds the ring write page.
      if ((sub >= nprd_pkg::OFS_01) && (sub <= nprd_pkg::OFS_06))
        station_r[3'(sub - nprd_pkg::OFS_01)] <= wbyte;
      else if (sub == nprd_pkg::OFS_07)
        RING_WRITE_PAGE <= wbyte;
      else if (sub >= nprd_pkg::OFS_08)
        hash_r[sub[2:0]] <= wbyte;
    end
  end

  always_comb
  begin
    // Byte 0 of each vector is the lowest offset, in the order software writes.
    for (int k = 0; k < 6; k++)
      STATION_ADDR[k*8 +: 8] = station_r[k];
    for (int m = 0; m < 8; m++)
      HASH_FILTER[m*8 +: 8] = hash_r[m];
  end

  // ==========================================================================
  // Read multiplexer
  // ==========================================================================
  always_comb
  begin
    rdata_nxt = nprd_pkg::ZERO_BYTE;
    case (ofs[4:3])
      nprd_pkg::RANGE_DATA: rdata_nxt = DATA_PORT_RDATA;
      nprd_pkg::RANGE_RESET: rdata_nxt = nprd_pkg::ZERO_BYTE;
      default:
      begin
        if (sub == nprd_pkg::OFS_COMMAND)
          rdata_nxt = command_r;
        else
        begin
          case (page)
            nprd_pkg::PAGE_0:
            begin
              case (sub)
                nprd_pkg::OFS_01: rdata_nxt = LOCAL_DMA_ADDR[7:0];
                nprd_pkg::OFS_02: rdata_nxt = LOCAL_DMA_ADDR[15:8];
                nprd_pkg::OFS_03: rdata_nxt = RING_BOUNDARY_PAGE;
                nprd_pkg::OFS_04: rdata_nxt = TX_STATUS & nprd_pkg::TX_STATUS_MASK;
                nprd_pkg::OFS_05: rdata_nxt = {4'h0, RETRY_TALLY} & nprd_pkg::RETRY_MASK;
                nprd_pkg::OFS_06: rdata_nxt = PREFETCH_BYTE;
                nprd_pkg::OFS_07: rdata_nxt = irq_status_r;
                nprd_pkg::OFS_08: rdata_nxt = REMOTE_CUR_ADDR[7:0];
                nprd_pkg::OFS_09: rdata_nxt = REMOTE_CUR_ADDR[15:8];
                nprd_pkg::OFS_0A: rdata_nxt = IDENT_0;
                nprd_pkg::OFS_0B: rdata_nxt = IDENT_1;
                nprd_pkg::OFS_0C: rdata_nxt = RX_STATUS & nprd_pkg::RX_STATUS_MASK;
                nprd_pkg::OFS_0D: rdata_nxt = TALLY_0;
                nprd_pkg::OFS_0E: rdata_nxt = TALLY_1;
                nprd_pkg::OFS_0F: rdata_nxt = TALLY_2;
                default: rdata_nxt = nprd_pkg::ZERO_BYTE;
              endcase
            end
            nprd_pkg::PAGE_1:
            begin
              if (sub <= nprd_pkg::OFS_06)
                rdata_nxt = station_r[3'(sub - nprd_pkg::OFS_01)];
              else if (sub == nprd_pkg::OFS_07)
                rdata_nxt = RING_WRITE_PAGE;
              else
                rdata_nxt = hash_r[sub[2:0]];
            end
            // Page 2 mirrors page-0 ring start/stop, transmit start and the four config registers so software can read its setup.
            nprd_pkg::PAGE_2:
            begin
              case (sub)
                nprd_pkg::OFS_01: rdata_nxt = RING_START_PAGE;
                nprd_pkg::OFS_02: rdata_nxt = RING_STOP_PAGE;
                nprd_pkg::OFS_04: rdata_nxt = TRANSMIT_START_PAGE;
                nprd_pkg::OFS_0C: rdata_nxt = RECEIVE_CONFIG;
                nprd_pkg::OFS_0D: rdata_nxt = TRANSMIT_CONFIG;
                nprd_pkg::OFS_0E: rdata_nxt = DATA_CONFIG;
                nprd_pkg::OFS_0F: rdata_nxt = INTERRUPT_MASK;
                default: rdata_nxt = nprd_pkg::ZERO_BYTE;
              endcase
            end
            // Page 3 lives in another block; here it reads as zero.
            default: rdata_nxt = nprd_pkg::ZERO_BYTE;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      WB_DAT_O <= 32'h00000000;
    else if (rd_en)
      // Taken at the accepting edge, so the byte stands with ack until the next read.
      WB_DAT_O <= {24'h000000, rdata_nxt};
  end

  // ==========================================================================
  // Data port and reset port strobes
  // ==========================================================================
  // Strobes fire once per bus access, in the acknowledging cycle.
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      DATA_PORT_RD <= 1'b0;
      DATA_PORT_WR <= 1'b0;
      DATA_PORT_WDATA <= nprd_pkg::ZERO_BYTE;
      SOFT_RESET_PULSE <= 1'b0;
    end
    else
    begin
      DATA_PORT_RD <= rd_en & data_sel;
      DATA_PORT_WR <= wr_en & data_sel;
      // Any access to the reset port pulses it; the core decides what that means.
      SOFT_RESET_PULSE <= req & reset_sel;
      if (wr_en)
        DATA_PORT_WDATA <= wbyte;
    end
  end

endmodule : nprd_top

/* File: test/nprd_assertions.sv */
// Port-level assertions for the paged register decoder.
`timescale 1ns/1ps
module nprd_checker (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [6:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic DATA_PORT_RD,
  input wire logic DATA_PORT_WR,
  input wire logic [7:0] DATA_PORT_WDATA,
  input wire logic SOFT_RESET_PULSE,
  input wire logic GO_COMMAND,
  input wire logic [2:0] REMOTE_DMA_COMMAND
);
  // ==========================================================================
  // Access decode
  logic take;
  logic wr;
  logic [1:0] rng;
  assign take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr = take & WB_WE_I & WB_SEL_I[0];
  assign rng = WB_ADR_I[6:5];
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  // ==========================================================================
  // Assertions
  AST_ACK_NEXT: assert property (take |=> WB_ACK_O)
    else $error("No ack on the cycle after an access.");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("Ack held for more than one cycle.");
  AST_DATA_RD: assert property (take && !WB_WE_I && rng == 2'h2 |=> DATA_PORT_RD)
    else $error("Data port read strobe missing.");
  AST_DATA_WR: assert property (wr && rng == 2'h2 |=>
    DATA_PORT_WR && DATA_PORT_WDATA == $past(WB_DAT_I[7:0]))
    else $error("Data port write strobe or byte wrong.");
  AST_STROBE_ACK: assert property ((DATA_PORT_RD || SOFT_RESET_PULSE) |-> WB_ACK_O)
    else $error("Port strobe without ack.");
  AST_RESET_PORT: assert property (take && rng == 2'h3 |=> SOFT_RESET_PULSE)
    else $error("Reset port pulse missing.");
  AST_RESET_READ: assert property (take && !WB_WE_I && rng == 2'h3 |=> WB_DAT_O == 32'h0)
    else $error("Reset port read not zero.");
  AST_UPPER_ZERO: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("Upper read data bits not zero.");
  AST_GO_CMD: assert property (wr && WB_ADR_I[6:2] == 5'h00 && WB_DAT_I[1] |=> GO_COMMAND)
    else $error("Go strobe missing.");
  AST_DMA_CMD: assert property (wr && WB_ADR_I[6:2] == 5'h00 |=>
    REMOTE_DMA_COMMAND == $past(WB_DAT_I[5:3]))
    else $error("Remote command field not loaded.");
  COV_DATA_RD: cover property (DATA_PORT_RD);
  COV_RESET: cover property (SOFT_RESET_PULSE);
  COV_GO: cover property (GO_COMMAND);
endmodule : nprd_checker
bind nprd_top nprd_checker i_chk (
  .SYS_CLK(SYS_CLK),
  .RESETN(RESETN),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O),
  .DATA_PORT_RD(DATA_PORT_RD),
  .DATA_PORT_WR(DATA_PORT_WR),
  .DATA_PORT_WDATA(DATA_PORT_WDATA),
  .SOFT_RESET_PULSE(SOFT_RESET_PULSE),
  .GO_COMMAND(GO_COMMAND),
  .REMOTE_DMA_COMMAND(REMOTE_DMA_COMMAND)
);

/* File: test/nprd_core_model.sv */
// Behavioural model of the controller core that feeds status to the decoder.
`timescale 1ns/1ps
module nprd_core_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic dp_rd,
  input wire logic dp_wr,
  output logic [15:0] lda,
  output logic [15:0] rca,
  output logic [7:0] txs,
  output logic [3:0] rt,
  output logic [7:0] pf,
  output logic [7:0] rxs,
  output logic [7:0] t0,
  output logic [7:0] t1,
  output logic [7:0] t2,
  output logic [6:0] irq,
  output logic [7:0] dprd
);
  // ==========================================================================
  // Status and event sources
  logic done_r;
  logic [7:0] next_r;
  assign lda = 16'h1234;
  assign rca = 16'h5678;
  // All status bits are set, so masked positions show whether they read zero.
  assign txs = 8'hFF;
  assign rt = 4'hF;
  assign pf = 8'h9C;
  assign rxs = 8'hFF;
  assign t0 = 8'h11;
  assign t1 = 8'h22;
  assign t2 = 8'h33;
  assign irq = {done_r, 6'h00};
  assign dprd = next_r;
  // A remote transfer reports done one cycle after each data port write.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      done_r <= 1'b0;
    else
      done_r <= dp_wr;
  end
  // The data port acts as a queue: each read moves on to the next byte.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      next_r <= 8'hC3;
    else if (dp_rd)
      next_r <= next_r + 8'h01;
  end
endmodule : nprd_core_model

/* File: test/tb_top.sv */
// Self-checking bench for the paged register decoder.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [6:0] adr = 7'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, dp_rd, dp_wr, rst_p, trig, go, halt;
  logic [2:0] rcmd;
  logic [3:0] rt;
  logic [6:0] irq;
  logic [7:0] dpw, rs, rp, bn, tp, rcf, tcf, dcf, imk, rwp, txs, pf, rxs, t0, t1, t2, dprd, q;
  logic [15:0] tlen, rsa, rcnt, lda, rca;
  logic [47:0] stn;
  logic [63:0] hash;
  logic [5:0] st;
  logic [3:0] wsel = 4'hF;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] e0 [16] = '{8'h00, 8'h34, 8'h12, 8'h33, 8'hDD, 8'h0F, 8'h9C, 8'h00,
    8'h78, 8'h56, 8'hA5, 8'h5A, 8'hF7, 8'h11, 8'h22, 8'h33};
  logic [7:0] e2 [16] = '{8'h00, 8'h11, 8'h22, 8'h00, 8'h44, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h1D, 8'h6E, 8'h7F};
  always #10 clk = ~clk;
  nprd_core_model i_core (.sys_clk(clk), .resetn(rstn), .dp_rd(dp_rd), .dp_wr(dp_wr),
    .lda(lda), .rca(rca), .txs(txs), .rt(rt), .pf(pf), .rxs(rxs), .t0(t0), .t1(t1),
    .t2(t2), .irq(irq), .dprd(dprd));
  // The identity bytes are the bench's own arbitrary choice, checked on read-back.
  nprd_top #(.IDENT_0(8'hA5), .IDENT_1(8'h5A)) i_dut (.SYS_CLK(clk), .RESETN(rstn),
    .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .LOCAL_DMA_ADDR(lda), .REMOTE_CUR_ADDR(rca), .TX_STATUS(txs),
    .RETRY_TALLY(rt), .PREFETCH_BYTE(pf), .RX_STATUS(rxs), .TALLY_0(t0), .TALLY_1(t1),
    .TALLY_2(t2), .IRQ_EVENTS(irq), .DATA_PORT_RDATA(dprd), .DATA_PORT_RD(dp_rd),
    .DATA_PORT_WR(dp_wr), .DATA_PORT_WDATA(dpw), .SOFT_RESET_PULSE(rst_p),
    .TRANSMIT_TRIGGER(trig), .GO_COMMAND(go), .HALT_COMMAND(halt),
    .REMOTE_DMA_COMMAND(rcmd), .RING_START_PAGE(rs), .RING_STOP_PAGE(rp),
    .RING_BOUNDARY_PAGE(bn), .TRANSMIT_START_PAGE(tp), .TRANSMIT_LENGTH(tlen),
    .REMOTE_START_ADDR(rsa), .REMOTE_COUNT(rcnt), .RECEIVE_CONFIG(rcf),
    .TRANSMIT_CONFIG(tcf), .DATA_CONFIG(dcf), .INTERRUPT_MASK(imk), .STATION_ADDR(stn),
    .RING_WRITE_PAGE(rwp), .HASH_FILTER(hash));
  // ==========================================================================
  // Bus tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Ack is read as the edge samples it, before that edge updates it; the loop ends
  // on ack, and only the watchdog ends a wait for an ack that never comes.
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= {a, 2'b00};
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = rdat[7:0];
    st = {dp_rd, dp_wr, rst_p, trig, go, halt};
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rdchk
  task automatic wrap_up();
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // ==========================================================================
  // Tests
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdchk(5'h00, 8'h21);
    rdchk(5'h07, 8'h80);
    for (int i = 1; i < 16; i++)
      if (i != 7)
        wb(1'b1, 5'(i), 8'(8'h11 * i));
    chk({rs, rp, bn, tp}, 32'h11223344);
    chk({tlen, rsa, rcnt}, 48'h66559988BBAA);
    chk({rcf, tcf, dcf, imk}, 32'h0C1D6E7F);
    wsel = 4'hE;
    wb(1'b1, 5'h03, 8'hEE);
    wsel = 4'hF;
    chk(bn, 8'h33);
    for (int i = 1; i < 16; i++)
      if (i != 7)
        rdchk(5'(i), e0[i]);
    wb(1'b1, 5'h00, 8'hA1);
    rdchk(5'h00, 8'hA1);
    for (int i = 1; i < 16; i++)
      rdchk(5'(i), e2[i]);
    wb(1'b1, 5'h00, 8'h61);
    for (int i = 1; i < 16; i++)
      wb(1'b1, 5'(i), 8'(8'h30 + i));
    for (int i = 1; i < 16; i++)
      rdchk(5'(i), 8'(8'h30 + i));
    chk({stn, rwp}, 56'h36353433323137);
    chk(hash, 64'h3F3E3D3C3B3A3938);
    wb(1'b1, 5'h00, 8'hE1);
    rdchk(5'h01, 8'h00);
    wb(1'b1, 5'h00, 8'h21);
    rdchk(5'h01, 8'h34);
    rdchk(5'h13, 8'hC3);
    chk(st, 6'h20);
    wb(1'b1, 5'h15, 8'h5A);
    chk({st, dpw}, 14'h105A);
    rdchk(5'h1C, 8'h00);
    chk(st, 6'h08);
    wb(1'b1, 5'h1F, 8'hFF);
    chk(st, 6'h08);
    wb(1'b1, 5'h00, 8'h26);
    chk({st, rcmd}, 9'h034);
    rdchk(5'h07, 8'h40);
    wb(1'b1, 5'h07, 8'h40);
    rdchk(5'h07, 8'h00);
    wb(1'b1, 5'h00, 8'h21);
    chk(st, 6'h01);
    rdchk(5'h07, 8'h80);
    wrap_up();
  end
  // 93 accesses of three cycles each; this limit leaves ample margin.
  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end
endmodule : tb_top
